/* logic/crc_consts.svh */
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH

// Command code of the role byte
`define CRC_CMD_ROLE 8'hd0

// Role encodings
`define CRC_ROLE_STD 8'h00
`define CRC_ROLE_ACTIVE 8'h01
`define CRC_ROLE_SB1 8'h02
`define CRC_ROLE_SB2 8'h03
`define CRC_ROLE_SB3 8'h04
`define CRC_ROLE_ALWAYS 8'h05
`define CRC_ROLE_RST 8'h00

// Load share level code, 10 mV per step
`define CRC_LVL_W 10
`define CRC_LVL_ZERO 10'h000
// Full rated output power, 8.0 V
`define CRC_LVL_FULL 10'h320
// Enable levels 3.2 V, 5.0 V, 6.7 V
`define CRC_EN_SB1 10'h140
`define CRC_EN_SB2 10'h1f4
`define CRC_EN_SB3 10'h29e
// Disable levels 1.44 V, 3.01 V, 4.52 V
`define CRC_DIS_SB1 10'h090
`define CRC_DIS_SB2 10'h12d
`define CRC_DIS_SB3 10'h1c4

// Timing
`define CRC_CLK_MHZ 50
`define CRC_WAKE_LIMIT_US 100
`define CRC_WAKE_LIMIT_CYC (`CRC_WAKE_LIMIT_US * `CRC_CLK_MHZ)

// One-hot state codes
`define CRC_ST_ON 4'h1
`define CRC_ST_SB 4'h2
`define CRC_ST_LOAD 4'h4
`define CRC_ST_WAKE 4'h8

// Synchroniser inputs: wake line, supply fault, output voltage fault
`define CRC_SYNC_W 3
// Reset as wake line high and no faults, so the bus is not pulled after reset
`define CRC_SYNC_RST 3'h4
`define CRC_SYNC_CLR 3'h0

`endif

/* logic/crc_pkg.sv */
`include "crc_consts.svh"

package crc_pkg;
    typedef enum logic [7:0] {
        CRC_STD = `CRC_ROLE_STD,
        CRC_ACTIVE = `CRC_ROLE_ACTIVE,
        CRC_SB1 = `CRC_ROLE_SB1,
        CRC_SB2 = `CRC_ROLE_SB2,
        CRC_SB3 = `CRC_ROLE_SB3,
        CRC_ALWAYS = `CRC_ROLE_ALWAYS
    } crc_role_t;

    typedef enum logic [3:0] {
        CRC_ST_ON = `CRC_ST_ON,
        CRC_ST_SB = `CRC_ST_SB,
        CRC_ST_LOAD = `CRC_ST_LOAD,
        CRC_ST_WAKE = `CRC_ST_WAKE
    } crc_state_t;

    typedef logic [`CRC_LVL_W-1:0] crc_lvl_t;
endpackage : crc_pkg

/* logic/crc_if.sv */
`include "crc_consts.svh"

interface crc_if;
    import crc_pkg::*;
    crc_lvl_t level;
    crc_lvl_t en_lvl;
    crc_lvl_t dis_lvl;
    logic above_en;
    logic below_dis;

    modport cmp (input level, input en_lvl, input dis_lvl, output above_en, output below_dis);
    modport ctl (output level, output en_lvl, output dis_lvl, input above_en, input below_dis);
endinterface : crc_if

/* logic/crc_cmp.sv */
module crc_cmp (
    crc_if.cmp th
);
    // Threshold pair compare
    assign th.above_en = (th.level > th.en_lvl);
    assign th.below_dis = (th.level < th.dis_lvl);
endmodule : crc_cmp

/* logic/crc_top.sv */
`include "crc_consts.svh"

module crc_top #(
    parameter int WAKE_LIMIT_CYC = `CRC_WAKE_LIMIT_CYC
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_write_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [7:0] cmd_wdata_in,
    input wire logic cmd_pec_ok_in,
    output logic cmd_ack_out,
    output logic cmd_nak_out,
    output logic [7:0] cmd_rdata_out,
    output crc_pkg::crc_role_t role_out,
    input wire logic shared_wake_line_in,
    output logic shared_wake_line_out,
    output logic shared_wake_line_oe_n_out,
    input wire logic supply_fault_in,
    input wire logic vout_fault_in,
    input wire crc_pkg::crc_lvl_t load_share_on_level_in,
    output logic converter_run_n_out
);
    import crc_pkg::*;

    logic [`CRC_SYNC_W-1:0] sync1_q, sync2_q;
    logic wake_s, fault_s, vfault_s, wake_prev_q, wake_fall, pull_low;
    crc_role_t role_q, role_d;
    logic ack_q, ack_d, nak_q, nak_d;
    logic [7:0] rdata_q, rdata_d;
    crc_state_t state_q, state_d;
    logic run_n_q, run_n_d, wout_q, wout_d, woe_n_q, woe_n_d;
    logic standby_role;
    crc_if th ();

    // Two-flop synchronisers for pin inputs
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_q <= `CRC_SYNC_RST;
            sync2_q <= `CRC_SYNC_RST;
            wake_prev_q <= 1'b1;
        end else begin
            sync1_q <= {shared_wake_line_in, supply_fault_in, vout_fault_in};
            sync2_q <= sync1_q;
            wake_prev_q <= wake_s;
        end
    end
    assign wake_s = sync2_q[2];
    assign fault_s = sync2_q[1];
    assign vfault_s = sync2_q[0];
    assign wake_fall = wake_prev_q & ~wake_s;
    assign pull_low = fault_s | vfault_s;
    assign standby_role = (role_q == CRC_SB1) || (role_q == CRC_SB2) ||
                          (role_q == CRC_SB3) || (role_q == CRC_ALWAYS);

    // Role byte command handling and wake-driven role reset
    always_comb begin
        role_d = role_q;
        ack_d = 1'b0;
        nak_d = 1'b0;
        rdata_d = rdata_q;
        if (cmd_valid_in) begin
            if (cmd_code_in != `CRC_CMD_ROLE) begin
                nak_d = 1'b1;
            end else if (!cmd_write_in) begin
                ack_d = 1'b1;
                rdata_d = role_q;
            end else if (cmd_pec_ok_in && (cmd_wdata_in <= `CRC_ROLE_ALWAYS)) begin
                ack_d = 1'b1;
                role_d = crc_role_t'(cmd_wdata_in);
            end else begin
                nak_d = 1'b1;
            end
        end
        if (wake_fall && standby_role) begin
            role_d = CRC_STD;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            role_q <= CRC_STD;
            ack_q <= 1'b0;
            nak_q <= 1'b0;
            rdata_q <= `CRC_ROLE_RST;
        end else begin
            role_q <= role_d;
            ack_q <= ack_d;
            nak_q <= nak_d;
            rdata_q <= rdata_d;
        end
    end

    // Threshold selection per standby position
    always_comb begin
        th.level = load_share_on_level_in;
        case (role_q)
            CRC_SB1: begin
                th.en_lvl = `CRC_EN_SB1;
                th.dis_lvl = `CRC_DIS_SB1;
            end
            CRC_SB2: begin
                th.en_lvl = `CRC_EN_SB2;
                th.dis_lvl = `CRC_DIS_SB2;
            end
            CRC_SB3: begin
                th.en_lvl = `CRC_EN_SB3;
                th.dis_lvl = `CRC_DIS_SB3;
            end
            default: begin
                th.en_lvl = `CRC_LVL_FULL;
                th.dis_lvl = `CRC_LVL_ZERO;
            end
        endcase
    end

    crc_cmp u_cmp (
        .th(th)
    );

    // Run state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            CRC_ST_ON, CRC_ST_SB, CRC_ST_WAKE: begin
                if (!standby_role) begin
                    state_d = CRC_ST_ON;
                end else if (!wake_s) begin
                    state_d = CRC_ST_WAKE;
                end else if (role_q != CRC_ALWAYS && th.above_en) begin
                    state_d = CRC_ST_LOAD;
                end else begin
                    state_d = CRC_ST_SB;
                end
            end
            CRC_ST_LOAD: begin
                if (!standby_role) begin
                    state_d = CRC_ST_ON;
                end else if (!wake_s) begin
                    state_d = CRC_ST_WAKE;
                end else if (role_q == CRC_ALWAYS || th.below_dis) begin
                    state_d = CRC_ST_SB;
                end
            end
            default: begin
                state_d = CRC_ST_ON;
            end
        endcase
        run_n_d = (state_d == CRC_ST_SB);
    end

    // Wake line drive
    always_comb begin
        if (role_q == CRC_ACTIVE) begin
            woe_n_d = 1'b0;
            wout_d = ~pull_low;
        end else begin
            woe_n_d = ~pull_low;
            wout_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= CRC_ST_ON;
            run_n_q <= 1'b0;
            wout_q <= 1'b0;
            woe_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            run_n_q <= run_n_d;
            wout_q <= wout_d;
            woe_n_q <= woe_n_d;
        end
    end

    assign cmd_ack_out = ack_q;
    assign cmd_nak_out = nak_q;
    assign cmd_rdata_out = rdata_q;
    assign role_out = role_q;
    assign shared_wake_line_out = wout_q;
    assign shared_wake_line_oe_n_out = woe_n_q;
    assign converter_run_n_out = run_n_q;

    // Helper logic for the checks
    logic seen_q;
    logic [15:0] wait_q;
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            seen_q <= 1'b0;
            wait_q <= 16'h0000;
        end else begin
            seen_q <= 1'b1;
            wait_q <= (!wake_s && run_n_q) ? wait_q + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_good_write;
        cmd_valid_in && cmd_write_in && cmd_code_in == `CRC_CMD_ROLE && cmd_pec_ok_in &&
        cmd_wdata_in <= `CRC_ROLE_ALWAYS && !(wake_fall && standby_role);
    endsequence
    sequence s_quiet_standby;
        wake_s && role_q == CRC_ALWAYS && state_q == CRC_ST_SB;
    endsequence

    AST_FAULT_PULL: assert property (
        pull_low |=> !shared_wake_line_oe_n_out && !shared_wake_line_out
    ) else $error("wake line not pulled on fault");
    AST_WAKE_RUN: assert property (!wake_s |=> !converter_run_n_out)
        else $error("converter not started by wake line");
    AST_WAKE_LIMIT: assert property (wait_q < 16'(WAKE_LIMIT_CYC))
        else $error("standby start too late");
    AST_NO_ACTIVE: assert property (!wake_s [*2] |-> !converter_run_n_out)
        else $error("converter off without active supply");
    AST_RESET_ROLE: assert property (
        !seen_q |-> role_q == CRC_STD && !converter_run_n_out
    ) else $error("bad reset role");
    AST_ACTIVE_ROLE: assert property (
        role_q == CRC_ACTIVE |=> !converter_run_n_out && !shared_wake_line_oe_n_out &&
            shared_wake_line_out == !$past(pull_low)
    ) else $error("active role misbehaves");
    AST_RELEASE: assert property (
        role_q != CRC_ACTIVE && !pull_low |=> shared_wake_line_oe_n_out
    ) else $error("wake line not released");
    AST_ALWAYS_SB: assert property (
        s_quiet_standby ##1 wake_s && role_q == CRC_ALWAYS |=> converter_run_n_out
    ) else $error("always standby started on load");
    AST_FALL_RESET: assert property (
        wake_fall && standby_role |=> role_q == CRC_STD
    ) else $error("role not reset on wake fall");
    AST_WRITE_ROLE: assert property (
        s_good_write |=> cmd_ack_out && role_q == $past(cmd_wdata_in)
    ) else $error("role write lost");
    AST_HYST: assert property (
        state_q == CRC_ST_LOAD && wake_s && standby_role && role_q != CRC_ALWAYS &&
            !th.below_dis |=> state_q == CRC_ST_LOAD
    ) else $error("load run dropped early");
endmodule : crc_top

/* verif/crc_peer.sv */
module crc_peer (
    input wire logic dut_out_in,
    input wire logic dut_oe_n_in,
    input wire logic peer_pull_low_in,
    input wire logic peer_drive_high_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Any low driver wins; an active supply drives high; else weak pull-down
    assign line_out = ((!dut_oe_n_in && !dut_out_in) || peer_pull_low_in) ? 1'b0 :
                      ((!dut_oe_n_in && dut_out_in) || peer_drive_high_in);
endmodule : crc_peer

/* verif/testbench.sv */
`include "crc_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import crc_pkg::*;
    logic clk, rst_b, valid, wr, pec, sfault, vfault, peer_low, peer_high;
    logic [7:0] code, wdata;
    crc_lvl_t lvl;
    logic ack, nak, wout, woe_n, run_n;
    logic [7:0] rdata;
    crc_role_t role;
    logic wline;
    int n_fail = 0;
    int compares = 0;
    crc_lvl_t en_t[3] = '{`CRC_EN_SB1, `CRC_EN_SB2, `CRC_EN_SB3};
    crc_lvl_t dis_t[3] = '{`CRC_DIS_SB1, `CRC_DIS_SB2, `CRC_DIS_SB3};

    crc_top #(.WAKE_LIMIT_CYC(8)) u_crc_top (.core_clk_in(clk), .rst_b_in(rst_b),
        .cmd_valid_in(valid), .cmd_write_in(wr), .cmd_code_in(code), .cmd_wdata_in(wdata),
        .cmd_pec_ok_in(pec), .cmd_ack_out(ack), .cmd_nak_out(nak), .cmd_rdata_out(rdata),
        .role_out(role), .shared_wake_line_in(wline), .shared_wake_line_out(wout),
        .shared_wake_line_oe_n_out(woe_n), .supply_fault_in(sfault), .vout_fault_in(vfault),
        .load_share_on_level_in(lvl), .converter_run_n_out(run_n));
    crc_peer u_crc_peer (.dut_out_in(wout), .dut_oe_n_in(woe_n), .peer_pull_low_in(peer_low),
        .peer_drive_high_in(peer_high), .line_out(wline));

    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("TB: compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // One byte command, answer looked at in the cycle after the taking edge
    task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] d,
                       input logic p, input logic ok);
        valid = 1'b1;
        wr = w;
        code = c;
        wdata = d;
        pec = p;
        tick(1);
        chk("ack", 8'(ok), 8'(ack));
        chk("nak", 8'(!ok), 8'(nak));
        valid = 1'b0;
        tick(1);
    endtask : cmd

    task automatic rd_role(input logic [7:0] exp);
        cmd(1'b0, `CRC_CMD_ROLE, 8'h00, 1'b0, 1'b1);
        chk("rdata", exp, rdata);
    endtask : rd_role

    // Watchdog against a hang
    initial begin
        #50us;
        n_fail++;
        report_and_stop();
    end

    initial begin
        {valid, wr, pec, sfault, vfault, peer_low, rst_b} = '0;
        peer_high = 1'b1;
        code = 8'h00;
        wdata = 8'h00;
        lvl = '0;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        chk("role", 8'h00, role);
        chk("run_n", 8'h00, 8'(run_n));
        tick(5);
        rd_role(8'h00);
        // Every role code written and read back
        for (int r = 0; r < 6; r++) begin
            cmd(1'b1, `CRC_CMD_ROLE, 8'(r), 1'b1, 1'b1);
            rd_role(8'(r));
        end
        // Refusals leave the role untouched
        cmd(1'b1, 8'hd1, 8'h00, 1'b1, 1'b0);
        cmd(1'b1, `CRC_CMD_ROLE, 8'h06, 1'b1, 1'b0);
        cmd(1'b1, `CRC_CMD_ROLE, 8'h01, 1'b0, 1'b0);
        cmd(1'b0, 8'hcf, 8'h00, 1'b0, 1'b0);
        rd_role(8'h05);
        lvl = `CRC_LVL_FULL;
        tick(3);
        chk("run_n always standby", 8'h01, 8'(run_n));
        // Standby positions: enable, hysteresis, disable
        for (int i = 0; i < 3; i++) begin
            lvl = '0;
            cmd(1'b1, `CRC_CMD_ROLE, 8'(i + 2), 1'b1, 1'b1);
            tick(3);
            chk("run_n idle", 8'h01, 8'(run_n));
            lvl = en_t[i] + 10'h001;
            tick(3);
            chk("run_n load on", 8'h00, 8'(run_n));
            lvl = dis_t[i];
            tick(3);
            chk("run_n hysteresis", 8'h00, 8'(run_n));
            lvl = dis_t[i] - 10'h001;
            tick(3);
            chk("run_n load off", 8'h01, 8'(run_n));
        end
        // No active supply holds the line high: every supply runs
        peer_high = 1'b0;
        tick(3);
        chk("run_n no active", 8'h00, 8'(run_n));
        chk("role no active", 8'h00, role);
        peer_high = 1'b1;
        cmd(1'b1, `CRC_CMD_ROLE, 8'h04, 1'b1, 1'b1);
        tick(3);
        chk("run_n active back", 8'h01, 8'(run_n));
        // Peer pulls the wake line low
        peer_low = 1'b1;
        tick(3);
        chk("run_n wake", 8'h00, 8'(run_n));
        chk("role wake", 8'h00, role);
        peer_low = 1'b0;
        tick(3);
        rd_role(8'h00);
        chk("oe_n healthy", 8'h01, 8'(woe_n));
        cmd(1'b1, `CRC_CMD_ROLE, 8'h03, 1'b1, 1'b1);
        tick(3);
        chk("run_n rearmed", 8'h01, 8'(run_n));
        chk("oe_n standby", 8'h01, 8'(woe_n));
        // Own fault pulls the line low
        sfault = 1'b1;
        tick(3);
        chk("oe_n fault", 8'h00, 8'(woe_n));
        chk("wout fault", 8'h00, 8'(wout));
        tick(3);
        chk("run_n fault", 8'h00, 8'(run_n));
        chk("role fault", 8'h00, role);
        sfault = 1'b0;
        tick(3);
        chk("oe_n cleared", 8'h01, 8'(woe_n));
        // Active role drives the line high while healthy
        cmd(1'b1, `CRC_CMD_ROLE, 8'h01, 1'b1, 1'b1);
        tick(3);
        chk("oe_n active", 8'h00, 8'(woe_n));
        chk("wout active", 8'h01, 8'(wout));
        chk("run_n active", 8'h00, 8'(run_n));
        vfault = 1'b1;
        tick(3);
        chk("wout vfault", 8'h00, 8'(wout));
        vfault = 1'b0;
        tick(3);
        chk("wout recovered", 8'h01, 8'(wout));
        // Reset in mid-run returns to standard redundancy
        rst_b = 1'b0;
        tick(2);
        chk("role reset", 8'h00, role);
        chk("run_n reset", 8'h00, 8'(run_n));
        chk("oe_n reset", 8'h01, 8'(woe_n));
        rst_b = 1'b1;
        tick(2);
        rd_role(8'h00);
        report_and_stop();
    end
endmodule : testbench
